//--- core/iocs_ctrl.sv
// How it works
// RULE1 - factory state: controller stays disabled after power-on, its indicators dark.
// RULE2 - receiving project data moves the controller into system start-up.
// RULE3 - start-up assigns every IO device its configured IP address by discovery.
// RULE4 - stored project at power-on starts start-up alone and runs it through.
// RULE5 - start-up builds communication and application relation with each IO device.
// RULE6 - bus fault indicator steady on when devices configured but cable missing.
// RULE7 - start-up on valid project data flashes the bus fault indicator.
// RULE8 - indicator blinks while any configured device lacks cyclic data exchange.
// RULE9 - indicator off when all devices exchange data, whatever the mode switch.
// RULE10 - configuration passes to controller at power-on and each new configuration.
// RULE11 - CPU stopped: telegrams still sent, marked invalid, output data zero.
// RULE12 - CPU stopped: inputs still received and copied into CPU input area.
// RULE13 - CPU running: output image fetched cyclically and sent to devices.
// RULE14 - missing cable steady-on outranks the blinking start-up indications.
`timescale 1ns/1ps
`default_nettype none
module iocs_ctrl
   import iocs_pkg::*;
#(
   parameter int unsigned DEVS        = iocs_pkg::DEV_MAX,
   parameter int unsigned BLINK_HALF  = iocs_pkg::BLINK_HALF_CYC,
   parameter int unsigned CYCLE       = iocs_pkg::CYCLE_CYC
) (
   input  wire logic                          clock,
   input  wire logic                          reset_n,
   input  wire logic                          project_stored,
   input  wire logic                          project_load,
   input  wire logic [iocs_pkg::DEV_MAX-1:0]  dev_configured,
   input  wire logic                          cable_present,
   input  wire logic                          cpu_run,
   input  wire logic                          mode_switch,
   input  wire logic                          ip_ack,
   input  wire logic                          rel_ack,
   input  wire logic [iocs_pkg::DEV_MAX-1:0]  dev_exchanging,
   input  wire logic [iocs_pkg::DATA_W-1:0]   out_image,
   input  wire logic                          in_valid,
   input  wire logic [iocs_pkg::DATA_W-1:0]   in_data,
   output logic                               ctrl_enabled,
   output logic                               cfg_push,
   output logic                               ip_req,
   output logic                               rel_req,
   output logic [2:0]                         dev_index,
   output logic                               image_fetch,
   output logic                               tx_valid,
   output logic                               tx_data_valid,
   output logic [iocs_pkg::DATA_W-1:0]        tx_data,
   output logic                               cpu_in_we,
   output logic [iocs_pkg::DATA_W-1:0]        cpu_in_data,
   output logic                               bus_fault_indicator
);
   if (DEVS < 1 || DEVS > DEV_MAX) $error("device count out of range");
   if (BLINK_HALF < 1 || CYCLE < 2) $error("timing counts too small");

   iocs_state_e          state_reg, state_next;
   logic [2:0]           idx_reg, idx_next;
   logic                 req_reg, req_next;
   logic                 cfg_reg, cfg_next;
   logic                 fetch_reg, fetch_next;
   logic                 txv_reg, txv_next;
   logic                 txdv_reg, txdv_next;
   logic [DATA_W-1:0]    txd_reg, txd_next;
   logic                 inwe_reg, inwe_next;
   logic [DATA_W-1:0]    ind_reg, ind_next;
   logic                 bf_reg, bf_next;
   logic [31:0]          blink_reg, blink_next;
   logic                 phase_reg, phase_next;
   logic                 startup_reg, startup_next;
   logic                 strap_done_reg, strap_done_next;
   logic                 cyc_tick;
   logic [DEV_MAX-1:0]   dev_mask;
   logic                 any_cfg;
   logic                 all_exch;
   logic                 last_dev;

   // cycle strobe paces the telegrams
   iocs_tick #(.PERIOD(CYCLE)) u_cycle (
      .clock   (clock),
      .reset_n (reset_n),
      .tick    (cyc_tick)
   );

   function automatic logic [2:0] next_cfg_dev(input logic [DEV_MAX-1:0] m, input logic [2:0] from);
      logic [2:0] r;
      r = from;
      for (int i = DEV_MAX - 1; i >= 0; i--) begin
         if (i > int'(from) && m[i]) r = 3'(i);
      end
      return r;
   endfunction

   function automatic logic [2:0] first_cfg_dev(input logic [DEV_MAX-1:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = DEV_MAX - 1; i >= 0; i--) begin
         if (m[i]) r = 3'(i);
      end
      return r;
   endfunction

   always_comb begin
      dev_mask = DEV_NONE;
      for (int i = 0; i < DEV_MAX; i++) begin
         if (i < int'(DEVS)) dev_mask[i] = dev_configured[i];
      end
      any_cfg  = (dev_mask != DEV_NONE);
      all_exch = ((dev_exchanging & dev_mask) == dev_mask);
      last_dev = (next_cfg_dev(dev_mask, idx_reg) == idx_reg);
   end

   // sequencer
   always_comb begin
      state_next      = state_reg;
      idx_next        = idx_reg;
      req_next        = req_reg;
      cfg_next        = 1'b0;
      startup_next    = startup_reg;
      strap_done_next = 1'b1;
      unique case (state_reg)
         IOCS_OFF: begin
            // stays dark until project data exist
            if (!strap_done_reg && project_stored) begin //RULE4
               state_next   = IOCS_ASSIGN_IP; //RULE4
               cfg_next     = 1'b1; //RULE10
               startup_next = 1'b1;
               idx_next     = first_cfg_dev(dev_mask);
               req_next     = any_cfg;
            end else if (project_load) begin
               state_next   = IOCS_ASSIGN_IP; //RULE2
               cfg_next     = 1'b1; //RULE10
               startup_next = 1'b1;
               idx_next     = first_cfg_dev(dev_mask);
               req_next     = any_cfg;
            end
         end
         IOCS_WAIT_PROJECT: state_next = IOCS_OFF;
         IOCS_ASSIGN_IP: begin
            if (!any_cfg) begin
               state_next = IOCS_EXCHANGE;
               req_next   = 1'b0;
            end else if (ip_ack) begin //RULE3
               if (last_dev) begin
                  state_next = IOCS_RELATIONS;
                  idx_next   = first_cfg_dev(dev_mask);
               end else begin
                  idx_next = next_cfg_dev(dev_mask, idx_reg);
               end
            end
         end
         IOCS_RELATIONS: begin
            if (rel_ack) begin //RULE5
               if (last_dev) begin
                  state_next = IOCS_EXCHANGE;
                  req_next   = 1'b0;
               end else begin
                  idx_next = next_cfg_dev(dev_mask, idx_reg);
               end
            end
         end
         IOCS_EXCHANGE: begin
            if (all_exch) startup_next = 1'b0;
         end
      endcase
      // a fresh configuration restarts start-up from any active state
      if (state_reg != IOCS_OFF && project_load) begin
         state_next   = IOCS_ASSIGN_IP;
         cfg_next     = 1'b1; //RULE10
         startup_next = 1'b1;
         idx_next     = first_cfg_dev(dev_mask);
         req_next     = any_cfg;
      end
   end

   // cyclic process data
   always_comb begin
      fetch_next = 1'b0;
      txv_next   = 1'b0;
      txdv_next  = txdv_reg;
      txd_next   = txd_reg;
      inwe_next  = 1'b0;
      ind_next   = ind_reg;
      if (state_reg == IOCS_EXCHANGE) begin
         if (cyc_tick) begin
            txv_next = 1'b1;
            if (cpu_run) begin
               fetch_next = 1'b1; //RULE13
               txdv_next  = 1'b1; //RULE13
               txd_next   = out_image; //RULE13
            end else begin
               txdv_next = 1'b0; //RULE11
               txd_next  = OUT_ZERO; //RULE11
            end
         end
         // inputs flow regardless of run or stop
         if (in_valid) begin
            inwe_next = 1'b1; //RULE12
            ind_next  = in_data; //RULE12
         end
      end else begin
         txdv_next = 1'b0;
         txd_next  = OUT_ZERO;
      end
   end

   // indicator; mode switch deliberately ignored
   always_comb begin
      blink_next = blink_reg + 32'h0000_0001;
      phase_next = phase_reg;
      if (blink_reg >= 32'(BLINK_HALF - 1)) begin
         blink_next = 32'h0000_0000;
         phase_next = !phase_reg;
      end
      if (state_reg == IOCS_OFF) begin
         bf_next = 1'b0; //RULE1
      end else if (any_cfg && !cable_present) begin
         bf_next = 1'b1; //RULE6 RULE14
      end else if (startup_reg && !(state_reg == IOCS_EXCHANGE && all_exch)) begin
         bf_next = phase_reg; //RULE7 RULE8
      end else if (!all_exch) begin
         bf_next = phase_reg; //RULE8
      end else begin
         bf_next = 1'b0; //RULE9
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_reg      <= IOCS_OFF;
         idx_reg        <= 3'h0;
         req_reg        <= 1'b0;
         cfg_reg        <= 1'b0;
         fetch_reg      <= 1'b0;
         txv_reg        <= 1'b0;
         txdv_reg       <= 1'b0;
         txd_reg        <= OUT_ZERO;
         inwe_reg       <= 1'b0;
         ind_reg        <= OUT_ZERO;
         bf_reg         <= 1'b0;
         blink_reg      <= 32'h0000_0000;
         phase_reg      <= 1'b0;
         startup_reg    <= 1'b0;
         strap_done_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         idx_reg        <= idx_next;
         req_reg        <= req_next;
         cfg_reg        <= cfg_next;
         fetch_reg      <= fetch_next;
         txv_reg        <= txv_next;
         txdv_reg       <= txdv_next;
         txd_reg        <= txd_next;
         inwe_reg       <= inwe_next;
         ind_reg        <= ind_next;
         bf_reg         <= bf_next;
         blink_reg      <= blink_next;
         phase_reg      <= phase_next;
         startup_reg    <= startup_next;
         strap_done_reg <= strap_done_next;
      end
   end

   logic en_reg;
   always_ff @(posedge clock) begin
      if (!reset_n) en_reg <= 1'b0;
      else          en_reg <= (state_next != IOCS_OFF); //RULE1
   end

   logic ipq_reg;
   logic relq_reg;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ipq_reg  <= 1'b0;
         relq_reg <= 1'b0;
      end else begin
         ipq_reg  <= req_next && (state_next == IOCS_ASSIGN_IP); //RULE3
         relq_reg <= req_next && (state_next == IOCS_RELATIONS); //RULE5
      end
   end

   assign ctrl_enabled        = en_reg;
   assign cfg_push            = cfg_reg;
   assign ip_req              = ipq_reg;
   assign rel_req             = relq_reg;
   assign dev_index           = idx_reg;
   assign image_fetch         = fetch_reg;
   assign tx_valid            = txv_reg;
   assign tx_data_valid       = txdv_reg;
   assign tx_data             = txd_reg;
   assign cpu_in_we           = inwe_reg;
   assign cpu_in_data         = ind_reg;
   assign bus_fault_indicator = bf_reg;

   logic unused_ok;
   assign unused_ok = mode_switch;
endmodule
`default_nettype wire

//--- core/iocs_pkg.sv
`default_nettype none
package iocs_pkg;
   // two hertz blink for the bus fault indicator, half period in nanoseconds
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned BLINK_HALF_NS   = 250000000;
   localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_NS / CLK_PERIOD_NS;
   // cyclic telegram period
   localparam int unsigned CYCLE_NS        = 1000000;
   localparam int unsigned CYCLE_CYC       = CYCLE_NS / CLK_PERIOD_NS;
   localparam int unsigned DEV_MAX         = 8;
   localparam int unsigned DATA_W          = 32;
   localparam logic [DATA_W-1:0] OUT_ZERO  = 32'h0000_0000;
   localparam logic [DEV_MAX-1:0] DEV_NONE = 8'h00;

   typedef enum logic [2:0] {
      IOCS_OFF,
      IOCS_WAIT_PROJECT,
      IOCS_ASSIGN_IP,
      IOCS_RELATIONS,
      IOCS_EXCHANGE
   } iocs_state_e;
endpackage
`default_nettype wire

//--- core/iocs_tick.sv
`timescale 1ns/1ps
`default_nettype none
module iocs_tick #(
   parameter int unsigned PERIOD = 4
) (
   input  wire logic clock,
   input  wire logic reset_n,
   output logic      tick
);
   // refused at elaboration: a period below two never lets the counter wrap cleanly
   if (PERIOD < 2) $error("period too short");
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic        tick_reg;
   logic        tick_next;
   always_comb begin
      cnt_next  = cnt_reg + 32'h0000_0001;
      tick_next = 1'b0;
      if (cnt_reg == 32'(PERIOD - 1)) begin
         cnt_next  = 32'h0000_0000;
         tick_next = 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cnt_reg  <= 32'h0000_0000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end
   assign tick = tick_reg;
endmodule
`default_nettype wire

//--- bench/iocs_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iocs_ctrl_properties #(
   parameter int unsigned BLINK_HALF = 4
) (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        project_stored,
   input wire logic        project_load,
   input wire logic [7:0]  dev_configured,
   input wire logic        cable_present,
   input wire logic        cpu_run,
   input wire logic [7:0]  dev_exchanging,
   input wire logic [31:0] out_image,
   input wire logic        in_valid,
   input wire logic [31:0] in_data,
   input wire logic        ctrl_enabled,
   input wire logic        cfg_push,
   input wire logic        ip_req,
   input wire logic        rel_req,
   input wire logic        image_fetch,
   input wire logic        tx_valid,
   input wire logic        tx_data_valid,
   input wire logic [31:0] tx_data,
   input wire logic        cpu_in_we,
   input wire logic [31:0] cpu_in_data,
   input wire logic        bus_fault_indicator
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [7:0] same_cnt;
   logic       bfi_d;
   // cable loss, all devices exchanging and indicator changes restart the count, so only a stuck blink fires
   always_ff @(posedge clock) begin
      bfi_d <= bus_fault_indicator;
      if (!reset_n || !ctrl_enabled || !cable_present || (dev_configured & ~dev_exchanging) == 8'h00
          || bus_fault_indicator != bfi_d) begin
         same_cnt <= 8'h00;
      end else begin
         same_cnt <= same_cnt + 8'h01;
      end
   end
   AST_DARK: assert property (!ctrl_enabled |-> !bus_fault_indicator)
      else $error("indicator lit while disabled");
   AST_START: assert property (project_load |=> cfg_push && ctrl_enabled)
      else $error("no start after load");
   AST_STORED: assert property ($rose(reset_n) && project_stored |=> cfg_push)
      else $error("no start from stored project");
   AST_IPREQ: assert property (cfg_push && dev_configured != 8'h00 |-> ip_req)
      else $error("no address request");
   AST_ZERO: assert property (tx_valid && !$past(cpu_run) |-> !tx_data_valid && tx_data == 32'h0 && !image_fetch)
      else $error("stop telegram not zero");
   AST_FETCH: assert property (tx_valid && $past(cpu_run) |-> image_fetch && tx_data_valid && tx_data == $past(out_image))
      else $error("run telegram wrong");
   AST_PERIOD: assert property (tx_valid |=> !tx_valid [*7])
      else $error("telegrams too close");
   AST_COPY: assert property (in_valid && ctrl_enabled && !ip_req && !rel_req && !cfg_push && !project_load
      |=> cpu_in_we && cpu_in_data == $past(in_data))
      else $error("input not copied");
   AST_CABLE: assert property (ctrl_enabled && !cable_present && dev_configured != 8'h00 |=> bus_fault_indicator)
      else $error("no steady indicator");
   AST_CLEAR: assert property (ctrl_enabled && cable_present && !ip_req && !rel_req && !cfg_push && !project_load
      && (dev_configured & ~dev_exchanging) == 8'h00 |=> !bus_fault_indicator)
      else $error("indicator not off");
   AST_BLINK: assert property (same_cnt <= BLINK_HALF + 2)
      else $error("indicator not blinking");
endmodule
`default_nettype wire

//--- bench/iocs_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module iocs_dev_model (
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        ip_req,
   input wire logic        rel_req,
   input wire logic        cfg_push,
   input wire logic        tx_valid,
   input wire logic        slow,
   input wire logic [7:0]  dev_configured,
   input wire logic [7:0]  hold_mask,
   output logic            ip_ack,
   output logic            rel_ack,
   output logic            in_valid,
   output logic [7:0]      dev_exchanging,
   output logic [31:0]     in_data
);
   logic [3:0]  wait_cnt;
   logic [31:0] word_cnt;
   logic        joined;
   logic        rel_d;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         {ip_ack, rel_ack, in_valid, joined, rel_d} <= 5'h00;
         wait_cnt <= 4'h0;
         word_cnt <= 32'h0;
         in_data <= 32'h0;
      end else begin
         ip_ack <= 1'b0;
         rel_ack <= 1'b0;
         rel_d <= rel_req;
         wait_cnt <= 4'h0;
         if ((ip_req || rel_req) && !ip_ack && !rel_ack) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == (slow ? 4'h9 : 4'h1)) begin
               ip_ack <= ip_req;
               rel_ack <= rel_req;
            end
         end
         if (cfg_push) begin
            joined <= 1'b0;
         end else if (rel_d && !rel_req) begin
            joined <= 1'b1;
         end
         in_valid <= tx_valid;
         // a stale word is inverted so a late sample cannot match by luck
         if (tx_valid) begin
            word_cnt <= word_cnt + 32'h1;
            in_data <= 32'hc0de_0000 | word_cnt;
         end else if (in_valid) begin
            in_data <= ~in_data;
         end
      end
   end
   // held devices never join the exchange
   assign dev_exchanging = joined ? (dev_configured & ~hold_mask) : 8'h00;
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
   import iocs_pkg::*;
   logic        clock, reset_n, project_stored, project_load, cable_present, cpu_run, mode_switch, slow;
   logic        ip_ack, rel_ack, in_valid, ctrl_enabled, cfg_push, ip_req, rel_req, image_fetch;
   logic        tx_valid, tx_data_valid, cpu_in_we, bus_fault_indicator;
   logic [7:0]  dev_configured, hold_mask, dev_exchanging;
   logic [2:0]  dev_index;
   logic [31:0] out_image, in_data, tx_data, cpu_in_data, last_in;
   logic [2:0]  ip_idx[$], rel_idx[$];
   int          num_errors, tests_run, cycles, tg, on;
   iocs_ctrl #(.DEVS(8), .BLINK_HALF(4), .CYCLE(8)) iocs_ctrl_inst (.*);
   iocs_dev_model iocs_dev_model_inst (.*);
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (ip_ack && ip_req) ip_idx.push_back(dev_index);
      if (rel_ack && rel_req) rel_idx.push_back(dev_index);
      if (in_valid) last_in = in_data;
      if (cycles == 20000) begin
         num_errors++;
         final_report;
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task do_reset(input logic st);
      project_stored <= st;
      reset_n <= 1'b0;
      cyc(16);
      reset_n <= 1'b1;
   endtask
   // 0 telegram, 1 input copy, 2 configuration push; bounded so a hang is caught
   task wait_on(input int s);
      for (int i = 0; i < 300; i++) begin
         @(posedge clock);
         #1;
         if ((s == 0 && tx_valid) || (s == 1 && cpu_in_we) || (s == 2 && cfg_push)) break;
      end
   endtask
   task watch(input int n);
      logic p;
      tg = 0;
      on = 0;
      p = bus_fault_indicator;
      repeat (n) begin
         @(posedge clock);
         #1;
         if (bus_fault_indicator !== p) tg++;
         if (bus_fault_indicator === 1'b1) on++;
         p = bus_fault_indicator;
      end
   endtask
   task t_factory;
      do_reset(1'b0);
      cyc(20);
      #1;
      `CHK("ctrl_enabled", 1'b0, ctrl_enabled)
      `CHK("indicator", 1'b0, bus_fault_indicator)
      $display("test factory done");
   endtask
   task t_startup;
      @(posedge clock);
      project_load <= 1'b1;
      @(posedge clock);
      project_load <= 1'b0;
      #1;
      `CHK("cfg_push", 1'b1, cfg_push)
      `CHK("ctrl_enabled", 1'b1, ctrl_enabled)
      `CHK("ip_req", 1'b1, ip_req)
      wait_on(0);
      `CHK("tx_valid", 1'b1, tx_valid)
      `CHK("ip_count", 2, ip_idx.size())
      `CHK("rel_count", 2, rel_idx.size())
      `CHK("ip_order", 6'h10, {ip_idx[1], ip_idx[0]})
      `CHK("rel_order", 6'h10, {rel_idx[1], rel_idx[0]})
      $display("test startup done");
   endtask
   task t_data;
      @(posedge clock);
      cpu_run <= 1'b1;
      out_image <= 32'h5a3c_96e1;
      wait_on(0);
      wait_on(0);
      `CHK("tx_data", 32'h5a3c_96e1, tx_data)
      `CHK("image_fetch", 1'b1, image_fetch)
      wait_on(1);
      `CHK("cpu_in_data", last_in, cpu_in_data)
      @(posedge clock);
      cpu_run <= 1'b0;
      wait_on(0);
      wait_on(0);
      `CHK("tx_stop", 33'h0, {tx_data_valid, tx_data})
      wait_on(1);
      `CHK("cpu_in_stop", last_in, cpu_in_data)
      $display("test data done");
   endtask
   task t_led;
      for (int m = 0; m < 2; m++) begin
         @(posedge clock);
         mode_switch <= m[0];
         cyc(3);
         #1;
         `CHK("indicator_off", 1'b0, bus_fault_indicator)
      end
      @(posedge clock);
      hold_mask <= 8'h04;
      watch(20);
      `CHK("blink", 1'b1, tg >= 2)
      @(posedge clock);
      cable_present <= 1'b0;
      cyc(3);
      watch(16);
      `CHK("steady", 16, on)
      @(posedge clock);
      cable_present <= 1'b1;
      hold_mask <= 8'h00;
      $display("test indicator done");
   endtask
   task t_stored;
      slow <= 1'b1;
      do_reset(1'b1);
      wait_on(2);
      `CHK("cfg_push", 1'b1, cfg_push)
      watch(20);
      `CHK("flash", 1'b1, tg >= 2)
      wait_on(0);
      `CHK("tx_valid", 1'b1, tx_valid)
      $display("test stored done");
   endtask
   initial begin
      {reset_n, project_stored, project_load, cpu_run, mode_switch, slow} = 6'h00;
      cable_present = 1'b1;
      dev_configured = 8'h05;
      hold_mask = 8'h00;
      out_image = 32'h0;
      t_factory;
      t_startup;
      t_data;
      t_led;
      t_stored;
      final_report;
   end
endmodule
bind iocs_ctrl iocs_ctrl_properties #(.BLINK_HALF(BLINK_HALF)) iocs_ctrl_properties_inst (.*);
`default_nettype wire
